//--- testbench/tmon_front_model.sv
// measurement front end model answering each start with one sample
`timescale 1ns/1ps

module tmon_front_model
    import tmon_pkg::*;
(
    // clock and reset
    input wire logic                                clk,
    input wire logic                                rst_n,
    // front end link
    input wire logic                                measStart,
    output logic                                    measValid,
    output logic signed [tmon_pkg::TEMP_W-1:0]      measTemp,
    // stimulus
    input wire logic signed [tmon_pkg::TEMP_W-1:0]  tempIn,
    input wire logic                                wobble,
    input wire logic [3:0]                          delay
);
    import tmon_pkg::*;
    logic       busy_r;
    logic [3:0] cnt_r;
    logic [1:0] seq_r;

    ////////////////////////////////////////////////////////////////////////////
    // every fourth sample is 4 higher when wobbling, so means and singles differ
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            busy_r    <= 1'b0;
            cnt_r     <= 4'h0;
            seq_r     <= 2'h0;
            measValid <= 1'b0;
            measTemp  <= '0;
        end else begin
            measValid <= 1'b0;
            measTemp  <= ~measTemp;
            if (measStart) begin
                busy_r <= 1'b1;
                cnt_r  <= delay;
            end else if (busy_r && cnt_r != 4'h0) begin
                cnt_r <= cnt_r - 4'h1;
            end else if (busy_r) begin
                busy_r    <= 1'b0;
                measValid <= 1'b1;
                seq_r     <= seq_r + 2'h1;
                measTemp  <= tempIn + ((wobble && seq_r == 2'h3) ? 10'sd4 : 10'sd0);
            end
        end
    end
endmodule : tmon_front_model

//--- testbench/tmon_top_checker.sv
// port assertions of the temperature monitor
`timescale 1ns/1ps

module tmon_top_checker
    import tmon_pkg::*;
#(
    parameter int CONV_BASE_CYCLES = 20
) (
    // clock and reset
    input wire logic                                clk,
    input wire logic                                rst_n,
    input wire logic                                ce,
    // register bus
    input wire tmon_pkg::tmonAvsReq_t               avsReq,
    input wire logic [31:0]                         avsReadData,
    input wire logic                                avsWaitRequest,
    // front end
    input wire logic                                measStart,
    input wire logic                                measValid,
    input wire logic signed [tmon_pkg::TEMP_W-1:0]  measTemp,
    // pins and interrupt
    input wire tmon_pkg::tmonPins_t                 pins,
    input wire logic                                irq
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);

    logic req;

    assign req = avsReq.read | avsReq.write;

    ////////////////////////////////////////////////////////////////////////////
    reset_quiet_a: assert property ($rose(rst_n) |-> avsWaitRequest && !irq && pins == '0)
        else $error("outputs not at rest after reset");
    first_start_a: assert property ($rose(rst_n) |-> ##[1:2] measStart)
        else $error("no conversion start after reset");
    wait_one_a: assert property (!avsWaitRequest |=> avsWaitRequest)
        else $error("waitrequest low longer than one cycle");
    wait_bound_a: assert property (req && ce && avsWaitRequest |=> !avsWaitRequest)
        else $error("bus request not answered after one wait cycle");
    rdata_hold_a: assert property (avsWaitRequest |-> $stable(avsReadData))
        else $error("read data changed outside a transfer");
    rdata_upper_a: assert property (!avsWaitRequest |-> avsReadData[31:8] == 24'h0)
        else $error("upper read data bits not zero");
    start_pulse_a: assert property (measStart |=> !measStart)
        else $error("conversion start longer than one cycle");
    od_data_a: assert property (!pins.shutOut && !pins.alarmOut)
        else $error("open drain data not low");

    rd_done_c: cover property (avsReq.read && !avsWaitRequest);
    wr_done_c: cover property (avsReq.write && !avsWaitRequest);
    shut_on_c: cover property ($rose(pins.shutOe));
    alarm_on_c: cover property ($rose(pins.alarmOe));
    irq_on_c: cover property ($rose(irq));
endmodule : tmon_top_checker

bind tmon_top tmon_top_checker #(.CONV_BASE_CYCLES(CONV_BASE_CYCLES)) i_tmon_top_checker (
    .clk(clk), .rst_n(rst_n), .ce(ce), .avsReq(avsReq), .avsReadData(avsReadData),
    .avsWaitRequest(avsWaitRequest), .measStart(measStart), .measValid(measValid),
    .measTemp(measTemp), .pins(pins), .irq(irq));

//--- testbench/tmon_top_test.sv
// self-checking bench of the temperature monitor
`timescale 1ns/1ps
`define CHK(g, e) check(32'(g), 32'(e))

module tmon_top_test;
    import tmon_pkg::*;
    logic                       clk;
    logic                       rst_n;
    logic                       ce;
    tmonAvsReq_t                avsReq;
    logic [31:0]                avsReadData;
    logic                       avsWaitRequest;
    logic                       measStart;
    logic                       measValid;
    logic signed [TEMP_W-1:0]   measTemp;
    logic signed [TEMP_W-1:0]   tempIn;
    tmonPins_t                  pins;
    logic                       irq;
    logic                       wobble;
    logic [3:0]                 delay;
    logic [31:0]                rd;
    logic [7:0]                 hi, lo, sh, cfg, m, res;
    logic [3:0]                 st;
    logic [4:0]                 addrs [5] = '{ADDR_CFG, ADDR_HIGH, ADDR_LOW, ADDR_SHUT, ADDR_RATE};
    logic [7:0]                 rsts [5] = '{CFG_RST, HIGH_RST, LOW_RST, SHUT_RST, 8'(RATE_RST)};
    logic [3:0]                 rates [3] = '{4'h7, 4'h9, 4'hA};
    int                         errTotal, testsRun, cycles, seed, t, n;

    tmon_top #(.CONV_BASE_CYCLES(20)) i_tmon_top (.clk(clk), .rst_n(rst_n), .ce(ce),
        .avsReq(avsReq), .avsReadData(avsReadData), .avsWaitRequest(avsWaitRequest),
        .measStart(measStart), .measValid(measValid), .measTemp(measTemp), .pins(pins), .irq(irq));
    tmon_front_model i_tmon_front_model (.clk(clk), .rst_n(rst_n), .measStart(measStart),
        .measValid(measValid), .measTemp(measTemp), .tempIn(tempIn), .wobble(wobble), .delay(delay));

    ////////////////////////////////////////////////////////////////////////////
    initial clk = 1'b0;
    always #50 clk = ~clk;
    always @(posedge clk) begin
        cycles++;
        if (cycles == 40000) begin
            errTotal++;
            end_sim();
        end
    end

    task end_sim;
        $display("mismatches %0d comparisons %0d", errTotal, testsRun);
        if (errTotal == 0 && testsRun > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask : end_sim

    task check(input logic [31:0] g, input logic [31:0] e);
        testsRun++;
        if (g !== e) begin
            errTotal++;
            $display("ERROR at %0t got %h expected %h", $time, g, e);
        end
    endtask : check

    // one avalon transfer, held until waitrequest is seen low
    task automatic bus(input logic wr, input logic [4:0] a, input logic [7:0] d);
        int k;
        k = 0;
        @(posedge clk);
        avsReq <= '{read: !wr, write: wr, address: a, writedata: {24'h0, d}};
        do begin
            @(posedge clk);
            k++;
        end while (avsWaitRequest !== 1'b0 && k < 50);
        if (k >= 50) begin
            errTotal++;
            $display("ERROR at %0t bus hang address %h", $time, a);
        end
        rd = avsReadData;
        avsReq <= '0;
    endtask : bus

    task automatic wait_for(input bit useIrq, input int k);
        int c;
        c = 0;
        while (k > 0 && c < 3000) begin
            @(posedge clk);
            c++;
            if ((useIrq ? irq : measValid) === 1'b1)
                k--;
        end
        if (c >= 3000) begin
            errTotal++;
            $display("ERROR at %0t wait ran out %h", $time, k);
        end
    endtask : wait_for

    function automatic logic [7:0] enc(input int v, input bit ext);
        v = ext ? v + 64 : v;
        if (v < 0)
            v = 0;
        if (v > (ext ? 255 : 127))
            v = ext ? 255 : 127;
        return 8'(v);
    endfunction : enc

    ////////////////////////////////////////////////////////////////////////////
    initial begin
        seed = 55;
        rst_n = 1'b0;
        ce = 1'b1;
        avsReq = '0;
        tempIn = 10'sd25;
        wobble = 1'b0;
        delay = 4'h2;
        repeat (4) @(posedge clk);
        rst_n <= 1'b1;
        // reset values and an unmapped place
        for (int i = 0; i < 5; i++) begin
            bus(0, addrs[i], 8'h00);
            `CHK(rd, rsts[i]);
        end
        bus(1, 5'h03, 8'hFF);
        bus(0, 5'h03, 8'h00);
        `CHK(rd, 0);
        // random temperatures, limits and modes with corner cases first
        for (int i = 0; i < 12; i++) begin
            t = {$random(seed)} % 261 - 60;
            hi = 8'($random(seed));
            lo = 8'($random(seed));
            sh = 8'($random(seed));
            cfg = 8'($random(seed)) & 8'hA4;
            m = 8'($random(seed)) & 8'h0F;
            if (i == 0) begin
                t = 85; hi = 8'h55; lo = 8'h55; sh = 8'h54; cfg = 8'h00;
            end
            if (i == 1) begin
                t = -100; lo = 8'h01; cfg = 8'h04;
            end
            if (i == 2) begin
                t = 300; sh = 8'hFE; cfg = 8'h24;
            end
            if (i == 3) begin
                t = 120; hi = 8'h10; cfg = 8'h80;
            end
            tempIn <= 10'(t);
            delay <= 4'($random(seed) & 7);
            bus(1, ADDR_HIGH, hi);
            bus(1, ADDR_LOW, lo);
            bus(1, ADDR_SHUT, sh);
            bus(1, ADDR_CFG, cfg);
            bus(1, ADDR_MASK, m);
            wait_for(0, 2);
            repeat (4) @(posedge clk);
            bus(1, ADDR_STATUS, 8'h0F);
            wait_for(0, 1);
            repeat (4) @(posedge clk);
            res = enc(t, cfg[2]);
            bus(0, ADDR_TEMP, 8'h00);
            `CHK(rd, res);
            `CHK(pins.shutOe, res > sh);
            `CHK(pins.alarmOe, cfg[5] ? res > sh : !cfg[7] && (res > hi || res < lo));
            st = {1'b1, res > sh, res < lo, res > hi};
            bus(0, ADDR_STATUS, 8'h00);
            `CHK(rd, st);
            `CHK(irq, |(st & m[3:0]));
            bus(1, ADDR_STATUS, 8'h0F);
            bus(0, ADDR_STATUS, 8'h00);
            `CHK(rd, 0);
            `CHK(irq, 0);
        end
        // averaging at a slow rate, single samples at the fast ones
        wobble <= 1'b1;
        delay <= 4'h1;
        tempIn <= 10'sd40;
        bus(1, ADDR_CFG, 8'h00);
        bus(1, ADDR_MASK, 8'h08);
        for (int j = 0; j < 3; j++) begin
            bus(1, ADDR_RATE, 8'(rates[j]));
            for (int r = 0; r < 2; r++) begin
                bus(1, ADDR_STATUS, 8'h0F);
                repeat (2) @(posedge clk);
                wait_for(1, 1);
            end
            bus(0, ADDR_TEMP, 8'h00);
            if (rates[j] < RATE_AVG_LIMIT)
                `CHK(rd, 41);
            else
                `CHK(rd == 40 || rd == 44, 1);
        end
        // standby stops starts, pins still follow limit writes
        wobble <= 1'b0;
        tempIn <= 10'sd50;
        bus(1, ADDR_RATE, 8'h0F);
        bus(0, ADDR_RATE, 8'h00);
        `CHK(rd, RATE_MAX);
        bus(1, ADDR_RATE, 8'h08);
        bus(1, ADDR_SHUT, 8'h7F);
        wait_for(0, 2);
        bus(1, ADDR_CFG, 8'h40);
        repeat (100) @(posedge clk);
        n = 0;
        repeat (300) begin
            @(posedge clk);
            if (measStart === 1'b1)
                n++;
        end
        `CHK(n, 0);
        `CHK(pins.shutOe, 0);
        // clock enable low: a held write must be neither answered nor taken
        @(posedge clk);
        ce     <= 1'b0;
        avsReq <= '{read: 1'b0, write: 1'b1, address: ADDR_SHUT, writedata: 32'h00000010};
        repeat (20) @(posedge clk);
        `CHK(avsWaitRequest, 1);
        `CHK(pins.shutOe, 0);
        ce     <= 1'b1;
        avsReq <= '0;
        bus(1, ADDR_SHUT, 8'h10);
        repeat (3) @(posedge clk);
        `CHK(pins.shutOe, 1);
        bus(1, ADDR_CFG, 8'h00);
        wait_for(0, 1);
        end_sim();
    end
endmodule : tmon_top_test

//--- verilog/tmon_avg.sv
// constants package and sample averager of the temperature monitor
`timescale 1ns/1ps

package tmon_pkg;
    localparam int          TEMP_W          = 10;
    localparam int          DATA_W          = 8;
    localparam int          ADDR_W          = 5;
    localparam int          AVG_LOG2        = 4;
    localparam int          CLK_HZ          = 10_000_000;
    localparam int          CONV_RATE_MAX_HZ = 64;
    // register byte offsets
    localparam logic [4:0]  ADDR_TEMP       = 5'h00;
    localparam logic [4:0]  ADDR_CFG        = 5'h04;
    localparam logic [4:0]  ADDR_HIGH       = 5'h08;
    localparam logic [4:0]  ADDR_LOW        = 5'h0C;
    localparam logic [4:0]  ADDR_SHUT       = 5'h10;
    localparam logic [4:0]  ADDR_RATE       = 5'h14;
    localparam logic [4:0]  ADDR_STATUS     = 5'h18;
    localparam logic [4:0]  ADDR_MASK       = 5'h1C;
    // configuration fields
    localparam int          CFG_MASK_BIT    = 7;
    localparam int          CFG_STBY_BIT    = 6;
    localparam int          CFG_PIN_BIT     = 5;
    localparam int          CFG_RANGE_BIT   = 2;
    localparam logic [7:0]  CFG_WR_MASK     = 8'hE4;
    // status fields
    localparam int          STATUS_W        = 4;
    localparam int          ST_HIGH         = 0;
    localparam int          ST_LOW          = 1;
    localparam int          ST_SHUT         = 2;
    localparam int          ST_DONE         = 3;
    // reset values, rate maximum and averaging limit
    localparam logic [7:0]  CFG_RST         = 8'h00;
    localparam logic [7:0]  HIGH_RST        = 8'h55;
    localparam logic [7:0]  LOW_RST         = 8'h00;
    localparam logic [7:0]  SHUT_RST        = 8'h55;
    localparam logic [3:0]  RATE_RST        = 4'h8;
    localparam logic [3:0]  RATE_MAX        = 4'hA;
    localparam logic [3:0]  RATE_AVG_LIMIT  = 4'h8;
    // data format
    localparam logic signed [TEMP_W:0] EXT_OFFSET = 11'sh040;
    localparam logic signed [TEMP_W:0] DEF_MAX    = 11'sh07F;
    localparam logic signed [TEMP_W:0] EXT_MAX    = 11'sh0FF;
    localparam logic [7:0]  DEF_MAX_CODE    = 8'h7F;
    localparam logic [7:0]  EXT_MAX_CODE    = 8'hFF;
    localparam logic [4:0]  AVG_COUNT       = 5'h10;

    typedef struct packed {
        logic              read;
        logic              write;
        logic [ADDR_W-1:0] address;
        logic [31:0]       writedata;
    } tmonAvsReq_t;

    typedef struct packed {
        logic shutOut;
        logic shutOe;
        logic alarmOut;
        logic alarmOe;
    } tmonPins_t;
endpackage : tmon_pkg

////////////////////////////////////////////////////////////////////////////////

module tmon_avg #(
    parameter int SAMPLE_W = 10,
    parameter int LOG2_N   = 4
) (
    // clock and reset
    input  wire logic                       clk,
    input  wire logic                       rst_n,
    input  wire logic                       ce,
    // samples
    input  wire logic                       single,
    input  wire logic                       sampleValid,
    input  wire logic signed [SAMPLE_W-1:0] sample,
    // result
    output logic                            doneP,
    output logic signed [SAMPLE_W-1:0]      mean
);
    import tmon_pkg::*;

    if (LOG2_N < 1 || SAMPLE_W < 2) begin : gBadParam
        $error("tmon_avg: LOG2_N must be at least 1 and SAMPLE_W at least 2");
    end

    logic signed [SAMPLE_W+LOG2_N-1:0] acc_r;
    logic        [LOG2_N-1:0]          cnt_r;
    logic signed [SAMPLE_W+LOG2_N-1:0] sum;
    logic                              lastSample;

    assign sum        = acc_r + (SAMPLE_W+LOG2_N)'(sample);
    assign lastSample = (cnt_r == {LOG2_N{1'b1}});

    // accumulate and divide by the power-of-two count
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            acc_r <= '0;
            cnt_r <= '0;
            doneP <= 1'b0;
            mean  <= '0;
        end else if (ce) begin
            doneP <= 1'b0;
            if (sampleValid) begin
                if (single) begin
                    mean  <= sample;
                    doneP <= 1'b1;
                    acc_r <= '0;
                    cnt_r <= '0;
                end else if (lastSample) begin
                    mean  <= sum[SAMPLE_W+LOG2_N-1 -: SAMPLE_W];
                    doneP <= 1'b1;
                    acc_r <= '0;
                    cnt_r <= '0;
                end else begin
                    acc_r <= sum;
                    cnt_r <= cnt_r + 1'b1;
                end
            end
        end
    end
endmodule : tmon_avg

//--- verilog/tmon_top.sv
// temperature monitor back end: conversion control, limits, alarms, register bus
`timescale 1ns/1ps

module tmon_top
    import tmon_pkg::*;
#(
    parameter int CONV_BASE_CYCLES = tmon_pkg::CLK_HZ / tmon_pkg::CONV_RATE_MAX_HZ
) (
    // clock and reset
    input  wire logic                           clk,
    input  wire logic                           rst_n,
    input  wire logic                           ce,
    // avalon-mm slave
    input  wire tmon_pkg::tmonAvsReq_t          avsReq,
    output logic [31:0]                         avsReadData,
    output logic                                avsWaitRequest,
    // measurement front end
    output logic                                measStart,
    input  wire logic                           measValid,
    input  wire logic signed [tmon_pkg::TEMP_W-1:0] measTemp,
    // open-drain pins
    output tmon_pkg::tmonPins_t                 pins,
    // interrupt
    output logic                                irq
);
    import tmon_pkg::*;

    if (CONV_BASE_CYCLES < 2 || CONV_BASE_CYCLES > 4_000_000) begin : gBadParam
        $error("tmon_top: CONV_BASE_CYCLES out of range");
    end

    typedef enum logic [1:0] {CONV_IDLE, CONV_MEAS, CONV_FINISH} tmonConvState_t;

    ////////////////////////////////////////////////////////////////////////////
    // register storage

    logic [DATA_W-1:0]   result_r;
    logic [DATA_W-1:0]   cfg_r;
    logic [DATA_W-1:0]   high_r;
    logic [DATA_W-1:0]   low_r;
    logic [DATA_W-1:0]   shut_r;
    logic [3:0]          rate_r;
    logic [STATUS_W-1:0] status_r;
    logic [STATUS_W-1:0] irqMask_r;

    logic                waitReq_r;
    logic [31:0]         readData_r;
    logic                reqActive;
    logic                accept;
    logic                wrAccept;
    logic [31:0]         readMux;

    logic                alarmMaskBit;
    logic                standby;
    logic                pinSecondShut;
    logic                extRange;

    assign alarmMaskBit  = cfg_r[CFG_MASK_BIT];
    assign standby       = cfg_r[CFG_STBY_BIT];
    assign pinSecondShut = cfg_r[CFG_PIN_BIT];
    assign extRange      = cfg_r[CFG_RANGE_BIT];

    ////////////////////////////////////////////////////////////////////////////
    // avalon slave: one wait cycle, then the answer

    assign reqActive = avsReq.read | avsReq.write;
    assign accept    = reqActive & ~waitReq_r;
    assign wrAccept  = accept & avsReq.write;

    always_comb begin
        readMux = '0;
        unique case (avsReq.address)
            ADDR_TEMP:   readMux[DATA_W-1:0]   = result_r;
            ADDR_CFG:    readMux[DATA_W-1:0]   = cfg_r;
            ADDR_HIGH:   readMux[DATA_W-1:0]   = high_r;
            ADDR_LOW:    readMux[DATA_W-1:0]   = low_r;
            ADDR_SHUT:   readMux[DATA_W-1:0]   = shut_r;
            ADDR_RATE:   readMux[3:0]          = rate_r;
            ADDR_STATUS: readMux[STATUS_W-1:0] = status_r;
            ADDR_MASK:   readMux[STATUS_W-1:0] = irqMask_r;
            default:     readMux               = '0;
        endcase
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            waitReq_r  <= 1'b1;
            readData_r <= '0;
        end else if (ce) begin
            waitReq_r <= ~(reqActive & waitReq_r);
            if (avsReq.read & waitReq_r) begin
                readData_r <= readMux;
            end
        end
    end

    assign avsWaitRequest = waitReq_r;
    assign avsReadData    = readData_r;

    ////////////////////////////////////////////////////////////////////////////
    // software-written registers

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            cfg_r     <= CFG_RST;
            high_r    <= HIGH_RST;
            low_r     <= LOW_RST;
            shut_r    <= SHUT_RST;
            rate_r    <= RATE_RST;
            irqMask_r <= '0;
        end else if (ce && wrAccept) begin
            unique case (avsReq.address)
                ADDR_CFG:  cfg_r     <= avsReq.writedata[DATA_W-1:0] & CFG_WR_MASK;
                ADDR_HIGH: high_r    <= avsReq.writedata[DATA_W-1:0];
                ADDR_LOW:  low_r     <= avsReq.writedata[DATA_W-1:0];
                ADDR_SHUT: shut_r    <= avsReq.writedata[DATA_W-1:0];
                ADDR_RATE: rate_r    <= (avsReq.writedata[3:0] > RATE_MAX) ?
                                        RATE_MAX : avsReq.writedata[3:0];
                ADDR_MASK: irqMask_r <= avsReq.writedata[STATUS_W-1:0];
                default:   ;
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // conversion control

    tmonConvState_t           state_r;
    logic [31:0]              periodCnt_r;
    logic [31:0]              periodLen;
    logic [3:0]               rateShift;
    logic [4:0]               measLeft_r;
    logic                     convSingle_r;
    logic                     measStart_r;
    logic                     avgDone;
    logic signed [TEMP_W-1:0] avgMean;
    logic                     startConv;

    assign rateShift = RATE_MAX - rate_r;
    assign periodLen = 32'(CONV_BASE_CYCLES) << rateShift;
    assign startConv = (state_r == CONV_IDLE) && (periodCnt_r == '0) && !standby;

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            periodCnt_r <= '0;
        end else if (ce) begin
            if (startConv) begin
                periodCnt_r <= periodLen - 32'h00000001;
            end else if (periodCnt_r != '0) begin
                periodCnt_r <= periodCnt_r - 32'h00000001;
            end
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            state_r      <= CONV_IDLE;
            measLeft_r   <= '0;
            convSingle_r <= 1'b0;
            measStart_r  <= 1'b0;
        end else if (ce) begin
            measStart_r <= 1'b0;
            unique case (state_r)
                CONV_IDLE: begin
                    if (startConv) begin
                        convSingle_r <= (rate_r >= RATE_AVG_LIMIT);
                        measLeft_r   <= (rate_r >= RATE_AVG_LIMIT) ?
                                        5'h01 : AVG_COUNT;
                        measStart_r  <= 1'b1;
                        state_r      <= CONV_MEAS;
                    end
                end
                CONV_MEAS: begin
                    if (measValid) begin
                        measLeft_r <= measLeft_r - 5'h01;
                        if (measLeft_r == 5'h01) begin
                            state_r <= CONV_FINISH;
                        end else begin
                            measStart_r <= 1'b1;
                        end
                    end
                end
                CONV_FINISH: begin
                    if (avgDone) begin
                        state_r <= CONV_IDLE;
                    end
                end
            endcase
        end
    end

    assign measStart = measStart_r;

    tmon_avg #(
        .SAMPLE_W (TEMP_W),
        .LOG2_N   (AVG_LOG2)
    ) uAvg (
        .clk         (clk),
        .rst_n       (rst_n),
        .ce          (ce),
        .single      (convSingle_r),
        .sampleValid (measValid && (state_r == CONV_MEAS)),
        .sample      (measTemp),
        .doneP       (avgDone),
        .mean        (avgMean)
    );

    ////////////////////////////////////////////////////////////////////////////
    // result encoding and storage

    function automatic logic [DATA_W-1:0] encodeTemp(input logic signed [TEMP_W-1:0] t,
                                                     input logic                     ext);
        logic signed [TEMP_W:0] wide;
        wide = (TEMP_W+1)'(t);
        if (ext) begin
            wide = wide + EXT_OFFSET;
            if (wide < 0) begin
                encodeTemp = '0;
            end else if (wide > EXT_MAX) begin
                encodeTemp = EXT_MAX_CODE;
            end else begin
                encodeTemp = wide[DATA_W-1:0];
            end
        end else begin
            if (wide < 0) begin
                encodeTemp = '0;
            end else if (wide > DEF_MAX) begin
                encodeTemp = DEF_MAX_CODE;
            end else begin
                encodeTemp = wide[DATA_W-1:0];
            end
        end
    endfunction : encodeTemp

    logic [DATA_W-1:0] resultNxt;

    assign resultNxt = encodeTemp(avgMean, extRange);

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            result_r <= '0;
        end else if (ce && avgDone) begin
            result_r <= resultNxt;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // limit comparison, status and interrupt

    logic                overHigh;
    logic                underLow;
    logic                overShut;
    logic                newHigh;
    logic                newLow;
    logic                newShut;
    logic [STATUS_W-1:0] statusSet;
    logic [STATUS_W-1:0] statusClr;

    assign overHigh = result_r > high_r;
    assign underLow = result_r < low_r;
    assign overShut = result_r > shut_r;
    assign newHigh  = resultNxt > high_r;
    assign newLow   = resultNxt < low_r;
    assign newShut  = resultNxt > shut_r;

    always_comb begin
        statusSet = '0;
        if (avgDone) begin
            statusSet[ST_HIGH] = newHigh;
            statusSet[ST_LOW]  = newLow;
            statusSet[ST_SHUT] = newShut;
            statusSet[ST_DONE] = 1'b1;
        end
        statusClr = '0;
        if (wrAccept && avsReq.address == ADDR_STATUS) begin
            statusClr = avsReq.writedata[STATUS_W-1:0];
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            status_r <= '0;
            irq      <= 1'b0;
        end else if (ce) begin
            status_r <= (status_r & ~statusClr) | statusSet;
            irq      <= |(status_r & irqMask_r);
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // open-drain alarm pins, live against the stored result

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            pins <= '0;
        end else if (ce) begin
            pins.shutOut  <= 1'b0;
            pins.alarmOut <= 1'b0;
            pins.shutOe   <= overShut;
            if (pinSecondShut) begin
                pins.alarmOe <= overShut;
            end else begin
                pins.alarmOe <= (overHigh | underLow) & ~alarmMaskBit;
            end
        end
    end
endmodule : tmon_top
